// ===== rac_pkg.sv
package rac_pkg;

   localparam int unsigned NUM_SLOTS      = 10;
   localparam int unsigned CLK_MHZ        = 40;

   // power-up arbitration window, peer removal filter, relay feedback wait
   localparam int unsigned SETTLE_US      = 100;
   localparam int unsigned SETTLE_CYC     = SETTLE_US * CLK_MHZ;
   localparam int unsigned PEER_GONE_US   = 50;
   localparam int unsigned PEER_GONE_CYC  = PEER_GONE_US * CLK_MHZ;
   localparam int unsigned RELAY_CHK_US   = 20;
   localparam int unsigned RELAY_CHK_CYC  = RELAY_CHK_US * CLK_MHZ;

   localparam int unsigned TMR_W          = 12;
   localparam int unsigned CHK_W          = 10;

   localparam logic [TMR_W-1:0] SETTLE_LAST = TMR_W'(SETTLE_CYC - 1);
   localparam logic [TMR_W-1:0] GONE_LAST   = TMR_W'(PEER_GONE_CYC);
   localparam logic [CHK_W-1:0] CHK_LAST    = CHK_W'(RELAY_CHK_CYC);

   typedef enum logic [2:0] {
      RAC_ST_SETTLE,
      RAC_ST_ACTIVE,
      RAC_ST_STANDBY,
      RAC_ST_DISCOVER,
      RAC_ST_BACKUP
   } rac_role_e;

   typedef struct packed {
      rac_role_e        role;
      logic [TMR_W-1:0] tmr;
      logic [TMR_W-1:0] gone_cnt;
      logic             peer_seen_active;
      logic             ctrl_active;
      logic             disc_start;
      logic             pwr_led;
      logic             maj_led;
      logic             min_led;
      logic             maj_relay;
      logic             min_relay;
      logic [CHK_W-1:0] maj_chk;
      logic [CHK_W-1:0] min_chk;
      logic             maj_fault;
      logic             min_fault;
      logic             relay_fault;
   } rac_core_s;

   typedef struct packed {
      logic major;
      logic minor;
   } rac_merge_s;

   // role 0 is the settle state; relays start de-energised, i.e. both alarms asserted
   localparam rac_core_s  RAC_CORE_RST  = '0;
   localparam rac_merge_s RAC_MERGE_RST = '0;

endpackage

// ===== rac_alarm_if.sv
`timescale 1ns/10ps
interface rac_alarm_if;
   logic [rac_pkg::NUM_SLOTS-1:0] maj_rpt;
   logic [rac_pkg::NUM_SLOTS-1:0] min_rpt;
   logic [rac_pkg::NUM_SLOTS-1:0] en;
   logic                          major;
   logic                          minor;

   modport merge (input maj_rpt, input min_rpt, input en, output major, output minor);
   modport core  (output maj_rpt, output min_rpt, output en, input major, input minor);
endinterface

// ===== rac_alarm_merge.sv
`timescale 1ns/10ps
module rac_alarm_merge (
   input  wire logic       sys_clk_i,  // system clock
   input  wire logic       rst_b_i,    // sync reset, active low
   rac_alarm_if.merge      alm         // slot reports in, frame levels out
);
   rac_pkg::rac_merge_s q;
   rac_pkg::rac_merge_s d;

   always_comb begin
      d.major = |(alm.maj_rpt & alm.en);
      d.minor = |(alm.min_rpt & alm.en);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         q <= rac_pkg::RAC_MERGE_RST;
      end else begin
         q <= d;
      end
   end

   assign alm.major = q.major;
   assign alm.minor = q.minor;
endmodule

// ===== rac_ctrl.sv
`timescale 1ns/10ps
// Contract
// - Both full modules powered together: upper slot takes the active role.
// - Frame already on: first inserted module takes the active role; a full-function one keeps it, an alarm-only one yields to a full peer.
// - Active full module lights its active indicator; standby keeps it dark.
// - Standby never takes over just because the active module failed.
// - Active removed: full standby starts discovery once the removal has lasted 50 us.
// - Discovery done: standby goes active, takes control, enables network.
// - Full-function module always wins the active role over alarm-only.
// - Alarm-only backup keeps alarm outputs, offers no communication or control.
// - Red major indicator lit while any enabled urgent condition exists.
// - Yellow minor indicator lit while any enabled non-urgent condition exists.
// - Green power indicator lit while frame supply operates.
// - Active indicator lit only while full module controls the frame.
// - Each slot's alarms individually enabled; disabled ones drive nothing.
// - Relay energised while its alarm is absent and frame powered.
// - Alarm asserted: relay de-energised.
// - Relay or drive failure leaves relay de-energised, read as alarm.
// - Frame power loss de-energises both relays.
module rac_ctrl (
   input  wire logic                          sys_clk_i,          // 40 MHz system clock
   input  wire logic                          rst_b_i,            // sync reset, active low
   input  wire logic                          full_func_i,        // this module is full-function
   input  wire logic                          upper_slot_i,       // this module sits in upper slot
   input  wire logic                          peer_present_i,     // peer module seated
   input  wire logic                          peer_full_func_i,   // peer is full-function
   input  wire logic                          peer_active_i,      // peer holds frame control
   input  wire logic                          discovery_done_i,   // discovery finished, pulse/level
   input  wire logic                          frame_pwr_ok_i,     // frame supply operating
   input  wire logic [rac_pkg::NUM_SLOTS-1:0] maj_rpt_i,          // per-slot major reports
   input  wire logic [rac_pkg::NUM_SLOTS-1:0] min_rpt_i,          // per-slot minor reports
   input  wire logic [rac_pkg::NUM_SLOTS-1:0] alarm_en_i,         // per-slot alarm enables
   input  wire logic                          maj_relay_sense_i,  // major relay coil feedback
   input  wire logic                          min_relay_sense_i,  // minor relay coil feedback
   output logic                               active_led_o,       // active indicator
   output logic                               peer_active_o,      // control held, to peer
   output logic                               comm_en_o,          // network/control enable
   output logic                               discovery_start_o,  // one-cycle discovery kick
   output logic                               pwr_led_o,          // green power indicator
   output logic                               maj_led_o,          // red major indicator
   output logic                               min_led_o,          // yellow minor indicator
   output logic                               maj_relay_o,        // major relay drive, 1=energised
   output logic                               min_relay_o,        // minor relay drive, 1=energised
   output logic                               relay_fault_o       // relay feedback failure seen
);

   rac_pkg::rac_core_s q;
   rac_pkg::rac_core_s d;
   rac_alarm_if        alm ();

   assign alm.maj_rpt = maj_rpt_i;
   assign alm.min_rpt = min_rpt_i;
   assign alm.en      = alarm_en_i;

   rac_alarm_merge i_rac_alarm_merge (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .alm       (alm)
   );

   // feedback counter: runs while coil driven but not sensed; saturates at the limit
   function automatic logic [rac_pkg::CHK_W-1:0] chk_next(
      input logic                     drive,
      input logic                     sense,
      input logic [rac_pkg::CHK_W-1:0] cnt
   );
      if (!drive || sense) begin
         chk_next = '0;
      end else if (cnt == rac_pkg::CHK_LAST) begin
         chk_next = cnt;
      end else begin
         chk_next = cnt + 1'b1;
      end
   endfunction

   // who gets the role when both sides come up together
   function automatic logic wins_arbitration(
      input logic self_full,
      input logic peer_full,
      input logic upper
   );
      if (self_full != peer_full) begin
         wins_arbitration = self_full;
      end else begin
         wins_arbitration = upper;
      end
   endfunction

   logic peer_gone;
   logic drive_ok;

   always_comb begin
      d            = q;
      d.disc_start = 1'b0;
      peer_gone    = (q.gone_cnt == rac_pkg::GONE_LAST);

      // filter connector bounce so a reseat does not look like a removal
      if (peer_present_i) begin
         d.gone_cnt = '0;
      end else if (!peer_gone) begin
         d.gone_cnt = q.gone_cnt + 1'b1;
      end

      unique case (q.role)
         rac_pkg::RAC_ST_SETTLE: begin
            d.tmr = q.tmr + 1'b1;
            if (peer_active_i) begin
               d.peer_seen_active = 1'b1;
            end
            if (q.tmr == rac_pkg::SETTLE_LAST) begin
               d.tmr = '0;
               if (q.peer_seen_active || peer_active_i) begin
                  d.role = rac_pkg::RAC_ST_STANDBY;
               end else if (!peer_present_i) begin
                  d.role = rac_pkg::RAC_ST_ACTIVE;
               end else if (wins_arbitration(full_func_i, peer_full_func_i, upper_slot_i)) begin
                  d.role = rac_pkg::RAC_ST_ACTIVE;
               end else begin
                  d.role = rac_pkg::RAC_ST_STANDBY;
               end
            end
         end
         rac_pkg::RAC_ST_ACTIVE: begin
            // a full module keeps the role whatever a later module does
            if (!full_func_i && peer_full_func_i && peer_active_i) begin
               d.role = rac_pkg::RAC_ST_STANDBY;
            end
         end
         rac_pkg::RAC_ST_STANDBY: begin
            // peer health is deliberately not watched: only removal hands over
            if (peer_gone) begin
               if (full_func_i) begin
                  d.role       = rac_pkg::RAC_ST_DISCOVER;
                  d.disc_start = 1'b1;
               end else begin
                  d.role = rac_pkg::RAC_ST_BACKUP;
               end
            end
         end
         rac_pkg::RAC_ST_DISCOVER: begin
            if (discovery_done_i) begin
               d.role = rac_pkg::RAC_ST_ACTIVE;
            end
         end
         rac_pkg::RAC_ST_BACKUP: begin
            if (peer_full_func_i && peer_active_i) begin
               d.role = rac_pkg::RAC_ST_STANDBY;
            end
         end
         default: begin
            d.role = rac_pkg::RAC_ST_SETTLE;
         end
      endcase

      // control, network and active lamp only for a full module holding the frame
      d.ctrl_active = full_func_i && (d.role == rac_pkg::RAC_ST_ACTIVE);

      // alarm path runs in every role so an alarm-only backup still reports
      d.pwr_led = frame_pwr_ok_i;
      d.maj_led = alm.major || q.maj_fault;
      d.min_led = alm.minor || q.min_fault;

      d.maj_chk = chk_next(q.maj_relay, maj_relay_sense_i, q.maj_chk);
      d.min_chk = chk_next(q.min_relay, min_relay_sense_i, q.min_chk);
      // faults are sticky: a flaky coil must not chatter the contacts
      if (q.maj_chk == rac_pkg::CHK_LAST) begin
         d.maj_fault = 1'b1;
      end
      if (q.min_chk == rac_pkg::CHK_LAST) begin
         d.min_fault = 1'b1;
      end
      // registered so the summary output comes straight from a flop
      d.relay_fault = d.maj_fault || d.min_fault;

      drive_ok    = frame_pwr_ok_i;
      d.maj_relay = drive_ok && !alm.major && !d.maj_fault;
      d.min_relay = drive_ok && !alm.minor && !d.min_fault;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         q <= rac_pkg::RAC_CORE_RST;
      end else begin
         q <= d;
      end
   end

   assign active_led_o      = q.ctrl_active;
   assign peer_active_o     = q.ctrl_active;
   assign comm_en_o         = q.ctrl_active;
   assign discovery_start_o = q.disc_start;
   assign pwr_led_o         = q.pwr_led;
   assign maj_led_o         = q.maj_led;
   assign min_led_o         = q.min_led;
   assign maj_relay_o       = q.maj_relay;
   assign min_relay_o       = q.min_relay;
   assign relay_fault_o     = q.relay_fault;

endmodule

// ===== rac_ctrl_props.sv
`timescale 1ns/10ps
module rac_ctrl_props (
   input wire logic       sys_clk_i,          // clock
   input wire logic       rst_b_i,            // reset
   input wire logic       full_func_i,        // full module
   input wire logic       peer_present_i,     // peer seated
   input wire logic       peer_active_i,      // peer control
   input wire logic       frame_pwr_ok_i,     // supply ok
   input wire logic [9:0] maj_rpt_i,          // major reports
   input wire logic [9:0] alarm_en_i,         // enables
   input wire logic       maj_relay_sense_i,  // coil feedback
   input wire logic       active_led_o,       // active led
   input wire logic       comm_en_o,          // network enable
   input wire logic       peer_active_o,      // control held
   input wire logic       discovery_start_o,  // discovery kick
   input wire logic       maj_led_o,          // major led
   input wire logic       maj_relay_o,        // major relay
   input wire logic       min_relay_o         // minor relay
);
   logic [9:0] cnt_q;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // counts drive-without-feedback cycles; the fault filter must give up in time
   always_ff @(posedge sys_clk_i) begin
      cnt_q <= (!rst_b_i || !(maj_relay_o && !maj_relay_sense_i)) ? 10'h000 : cnt_q + 10'h001;
   end
   a_loss_relays_off: assert property (!frame_pwr_ok_i |=> !maj_relay_o && !min_relay_o)
      else $error("relay energised without frame power");
   a_led_trio_same: assert property (active_led_o == comm_en_o && active_led_o == peer_active_o)
      else $error("active indicator and control outputs disagree");
   a_alonly_dark: assert property (!full_func_i |-> !active_led_o)
      else $error("alarm-only module lit active");
   a_major_led_on: assert property (|(maj_rpt_i & alarm_en_i) |-> ##2 maj_led_o)
      else $error("major led not lit for enabled report");
   a_major_relay_off: assert property (|(maj_rpt_i & alarm_en_i) |-> ##2 !maj_relay_o)
      else $error("major relay energised during alarm");
   a_fault_bounded: assert property (cnt_q < 10'h323)
      else $error("relay kept driven without feedback");
   a_disc_single: assert property (discovery_start_o |=> !discovery_start_o && !active_led_o)
      else $error("discovery kick not a single pulse");
   a_standby_holds: assert property (peer_present_i && peer_active_i && !active_led_o
      |=> !active_led_o)
      else $error("standby took control while peer active");
endmodule

// ===== rac_peer_model.sv
`timescale 1ns/10ps
module rac_peer_model (
   input  wire logic clk_i,         // system clock
   input  wire logic seat_i,        // peer seated
   input  wire logic hold_i,        // peer kept passive, still settling
   input  wire logic brk_i,         // break major coil
   input  wire logic dut_active_i,  // block holds control
   input  wire logic maj_drv_i,     // major coil drive
   input  wire logic min_drv_i,     // minor coil drive
   output logic      present_o,     // peer seated
   output logic      active_o,      // peer holds control
   output logic      maj_sense_o,   // major coil feedback
   output logic      min_sense_o    // minor coil feedback
);
   logic       act_q = 1'h0;
   logic [1:0] coil_q = 2'h0;
   // first seated keeps control; line pulled low when unseated
   always_ff @(posedge clk_i) begin
      act_q <= seat_i && !hold_i && (act_q || !dut_active_i);
   end
   // feedback lags the drive by one cycle, as a real coil would
   always_ff @(posedge clk_i) coil_q <= {maj_drv_i && !brk_i, min_drv_i};
   assign present_o = seat_i;
   assign active_o = act_q;
   assign maj_sense_o = coil_q[1];
   assign min_sense_o = coil_q[0];
endmodule

// ===== rac_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module rac_ctrl_tb;
   logic        sys_clk_i = 1'h0, rst_b_i = 1'h0, full = 1'h1, pwr = 1'h1;
   logic        done = 1'h0, seat = 1'h0, brk = 1'h0;
   logic        upper = 1'h1, pfull = 1'h1, hold = 1'h0;
   logic [9:0]  rmaj = 10'h000, rmin = 10'h000, en = 10'h000;
   logic        pp, pa, ms, ns, act, comm, pact, dst, pled, mjl, mnl, mjr, mnr, flt;
   logic [31:0] rs = 32'h0000AB15;
   logic [8:0]  q[$];
   logic [8:0]  note_v;
   int          err_count = 0, tests_run = 0, cycles = 0, pulses = 0;
   event        chk;
   initial forever #12.5 sys_clk_i = ~sys_clk_i;
   rac_ctrl i_rac_ctrl (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .full_func_i(full),
      .upper_slot_i(upper), .peer_present_i(pp), .peer_full_func_i(pfull), .peer_active_i(pa),
      .discovery_done_i(done), .frame_pwr_ok_i(pwr), .maj_rpt_i(rmaj), .min_rpt_i(rmin),
      .alarm_en_i(en), .maj_relay_sense_i(ms), .min_relay_sense_i(ns), .active_led_o(act),
      .peer_active_o(pact), .comm_en_o(comm), .discovery_start_o(dst), .pwr_led_o(pled),
      .maj_led_o(mjl), .min_led_o(mnl), .maj_relay_o(mjr), .min_relay_o(mnr),
      .relay_fault_o(flt));
   rac_peer_model i_rac_peer_model (.clk_i(sys_clk_i), .seat_i(seat), .brk_i(brk),
      .hold_i(hold), .dut_active_i(pact), .maj_drv_i(mjr), .min_drv_i(mnr), .present_o(pp),
      .active_o(pa), .maj_sense_o(ms), .min_sense_o(ns));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   function automatic logic [8:0] ev(input logic a, p, mj, mn);
      return {a, a, a, p, mj, mn, ~mj & p, ~mn & p, 1'h0};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic expect_v(input logic [8:0] e);
      @(negedge sys_clk_i);
      q.push_back(e);
      ->chk;
   endtask
   // cfg = {full, upper, peer full, peer held, seat}; static straps change only in reset
   task automatic reboot(input logic [4:0] cfg);
      @(posedge sys_clk_i) rst_b_i <= 1'h0;
      {full, upper, pfull, hold, seat} <= cfg;
      done <= 1'h0;
      cyc(2);
      rst_b_i <= 1'h1;
      cyc(4005);
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial forever begin
      @(chk);
      note_v = q.pop_front();
      `CHK({act, comm, pact, pled, mjl, mnl, mjr, mnr, flt}, note_v)
   end
   always @(negedge sys_clk_i) begin
      cycles++;
      if (dst === 1'h1) pulses++;
      if (cycles == 40000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      reboot(5'h1C);
      expect_v(ev(1'h1, 1'h1, 1'h0, 1'h0));
      repeat (24) begin
         @(posedge sys_clk_i) rs = xs(rs);
         rmaj <= rs[9:0];
         rmin <= rs[19:10];
         en <= rs[29:20];
         cyc(2);
         expect_v(ev(1'h1, 1'h1, |(rs[9:0] & rs[29:20]), |(rs[19:10] & rs[29:20])));
      end
      @(posedge sys_clk_i) en <= 10'h000;
      // second module only after the first shows active
      seat <= 1'h1;
      cyc(10);
      expect_v(ev(1'h1, 1'h1, 1'h0, 1'h0));
      @(posedge sys_clk_i) pwr <= 1'h0;
      cyc(2);
      expect_v(ev(1'h1, 1'h0, 1'h0, 1'h0));
      @(posedge sys_clk_i) pwr <= 1'h1;
      reboot(5'h1D);
      expect_v(ev(1'h0, 1'h1, 1'h0, 1'h0));
      @(posedge sys_clk_i) seat <= 1'h0;
      cyc(2010);
      `CHK(pulses, 1)
      expect_v(ev(1'h0, 1'h1, 1'h0, 1'h0));
      @(posedge sys_clk_i) done <= 1'h1;
      cyc(3);
      expect_v(ev(1'h1, 1'h1, 1'h0, 1'h0));
      // both seated, peer held passive: lower slot loses a tie but beats alarm-only
      reboot(5'h17);
      expect_v(ev(1'h0, 1'h1, 1'h0, 1'h0));
      reboot(5'h13);
      expect_v(ev(1'h1, 1'h1, 1'h0, 1'h0));
      reboot(5'h0C);
      expect_v(ev(1'h0, 1'h1, 1'h0, 1'h0));
      @(posedge sys_clk_i) rmaj <= 10'h008;
      rmin <= 10'h000;
      en <= 10'h008;
      cyc(2);
      expect_v(ev(1'h0, 1'h1, 1'h1, 1'h0));
      @(posedge sys_clk_i) en <= 10'h000;
      brk <= 1'h1;
      cyc(810);
      expect_v(9'h033);
      // let the watcher take the last note before the verdict
      cyc(1);
      report_and_stop();
   end
endmodule
bind rac_ctrl rac_ctrl_props i_rac_ctrl_props (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .full_func_i(full_func_i), .peer_present_i(peer_present_i), .peer_active_i(peer_active_i),
   .frame_pwr_ok_i(frame_pwr_ok_i), .maj_rpt_i(maj_rpt_i), .alarm_en_i(alarm_en_i),
   .maj_relay_sense_i(maj_relay_sense_i), .active_led_o(active_led_o), .comm_en_o(comm_en_o),
   .peer_active_o(peer_active_o), .discovery_start_o(discovery_start_o),
   .maj_led_o(maj_led_o), .maj_relay_o(maj_relay_o), .min_relay_o(min_relay_o));
